// ### logic/sdcb_consts.svh
// timing counts, field positions and reset values for the sdram command block
`ifndef SDCB_CONSTS_SVH
`define SDCB_CONSTS_SVH
`define SDCB_CLK_PERIOD_NS     10
`define SDCB_TRC_NS            70
`define SDCB_TRC_CYC           ((`SDCB_TRC_NS + `SDCB_CLK_PERIOD_NS - 1) / `SDCB_CLK_PERIOD_NS)
`define SDCB_READ_DQM_LAT      2
`define SDCB_BURST_LEN_DEF     4
`define SDCB_COL_MSB           7
`define SDCB_PRE_ALL_BIT       10
`define SDCB_MODE_RESET        12'h000
`define SDCB_ROW_RESET         12'h000
`define SDCB_EXIT_NOP_CYC      2
`endif

// ### logic/sdcb_pkg.sv
// types shared by the sdram command block modules
package sdcb_pkg;
  typedef enum logic [3:0] {
    SDCB_CMD_INHIBIT,
    SDCB_CMD_NOP,
    SDCB_CMD_ACTIVATE,
    SDCB_CMD_READ,
    SDCB_CMD_WRITE,
    SDCB_CMD_BURST_STOP,
    SDCB_CMD_PRECHARGE,
    SDCB_CMD_REFRESH,
    SDCB_CMD_LOAD_MODE
  } sdcb_cmd_t;

  typedef enum logic [2:0] {
    SDCB_PWR_ACTIVE,
    SDCB_PWR_POWER_DOWN,
    SDCB_PWR_SUSPEND,
    SDCB_PWR_SELF_REFRESH
  } sdcb_pwr_t;
endpackage : sdcb_pkg

// ### logic/sdcb_bank_if.sv
// interface carrying bank commands from core command logic to bank state array
`timescale 1ns/1ps
interface sdcb_bank_if;
  logic       act;
  logic       pre_one;
  logic       pre_all;
  logic       auto_pre;
  logic [1:0] bank;
  logic [1:0] auto_bank;
  logic [11:0] row;
  logic [3:0] bank_open;
  logic [47:0] open_rows;
  modport ctrl (output act, pre_one, pre_all, auto_pre, bank, auto_bank,
                output row, input bank_open, open_rows);
  modport banks (input act, pre_one, pre_all, auto_pre, bank, auto_bank,
                 input row, output bank_open, open_rows);
endinterface : sdcb_bank_if

// ### logic/sdcb_decode.sv
// command decoder from the four active-low strobes
`timescale 1ns/1ps
module sdcb_decode
  import sdcb_pkg::*;
(
  // strobes
  input  wire logic      cs_n_i,
  input  wire logic      ras_n_i,
  input  wire logic      cas_n_i,
  input  wire logic      we_n_i,
  // decoded
  output sdcb_pkg::sdcb_cmd_t cmd_o
);
  // truth table on cs, ras, cas, we
  always_comb begin
    cmd_o = SDCB_CMD_NOP;
    if (cs_n_i) begin
      cmd_o = SDCB_CMD_INHIBIT;
    end else begin
      case ({ras_n_i, cas_n_i, we_n_i})
        3'h3: cmd_o = SDCB_CMD_ACTIVATE;
        3'h5: cmd_o = SDCB_CMD_READ;
        3'h4: cmd_o = SDCB_CMD_WRITE;
        3'h6: cmd_o = SDCB_CMD_BURST_STOP;
        3'h2: cmd_o = SDCB_CMD_PRECHARGE;
        3'h1: cmd_o = SDCB_CMD_REFRESH;
        3'h0: cmd_o = SDCB_CMD_LOAD_MODE;
        default: cmd_o = SDCB_CMD_NOP;
      endcase
    end
  end
endmodule : sdcb_decode

// ### logic/sdcb_banks.sv
// per-bank idle / row-active state with open row
`timescale 1ns/1ps
`include "sdcb_consts.svh"
module sdcb_banks
  import sdcb_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  // bank commands
  sdcb_bank_if.banks bif
);
  logic [3:0]  open_q;
  logic [11:0] row_q [4];

  assign bif.bank_open = open_q;

  // one state slot per bank
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      assign bif.open_rows[g*12 +: 12] = row_q[g];
      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
          open_q[g] <= 1'b0;
          row_q[g]  <= `SDCB_ROW_RESET;
        end else if (clk_en_i) begin
          // precharge, own or burst-end auto precharge, wins over a same-cycle activate of this bank
          if (bif.pre_all ||
              (bif.pre_one && bif.bank == 2'(g)) ||
              (bif.auto_pre && bif.auto_bank == 2'(g))) begin
            open_q[g] <= 1'b0;
          end else if (bif.act && bif.bank == 2'(g)) begin
            open_q[g] <= 1'b1;
            row_q[g]  <= bif.row;
          end
        end
      end
    end
  endgenerate
endmodule : sdcb_banks

// ### logic/sdcb_core.sv
// sdram command, bank state, burst and byte-mask logic
`timescale 1ns/1ps
`include "sdcb_consts.svh"
module sdcb_core
  import sdcb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // command pins
  input  wire logic        clk_gate_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bank_select_i,
  input  wire logic [11:0] row_col_address_i,
  // byte masks
  input  wire logic        low_byte_mask_i,
  input  wire logic        high_byte_mask_i,
  // data pins, split into three signals
  input  wire logic [15:0] data_pins_i,
  output logic [15:0]      data_pins_o,
  output logic [15:0]      data_pins_oe_o,
  // array side
  output logic             array_wr_o,
  output logic [1:0]       array_bank_o,
  output logic [11:0]      array_row_o,
  output logic [7:0]       array_col_o,
  output logic [1:0]       array_byte_en_o,
  output logic [15:0]      array_wdata_o,
  input  wire logic [15:0] array_rdata_i,
  // status
  output logic [11:0]      mode_o,
  output logic [3:0]       bank_open_o,
  output logic             refresh_busy_o,
  output sdcb_pkg::sdcb_pwr_t pwr_state_o,
  output logic             burst_active_o
);
  localparam int TRC_CYC = `SDCB_TRC_CYC;
  localparam int BLEN    = `SDCB_BURST_LEN_DEF;

  sdcb_cmd_t   cmd;
  sdcb_bank_if bif ();
  logic        gate_q;
  logic        edge_ok;
  logic        burst_q;
  logic        burst_wr;
  logic        burst_ap;
  logic [1:0]  burst_bank;
  logic [7:0]  burst_col;
  logic [7:0]  burst_left;
  logic [3:0]  rf_cnt;
  logic [1:0]  mask_d1;
  logic        rd_d1;
  logic        burst_last;
  logic        self_ref;
  logic        start;

  sdcb_decode u_decode (
    .cs_n_i  (cs_n_i),
    .ras_n_i (ras_n_i),
    .cas_n_i (cas_n_i),
    .we_n_i  (we_n_i),
    .cmd_o   (cmd)
  );

  sdcb_banks u_banks (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (edge_ok),
    .bif       (bif)
  );

  // gate taken as it stands at the edge; low edges are void
  assign edge_ok  = clk_gate_i;
  assign self_ref = (pwr_state_o == SDCB_PWR_SELF_REFRESH);
  // refresh busy and self refresh block new commands
  assign start = edge_ok && !self_ref && (rf_cnt == 4'h0);

  // bank command strobes
  assign bif.act      = start && cmd == SDCB_CMD_ACTIVATE;
  assign bif.pre_one  = start && cmd == SDCB_CMD_PRECHARGE &&
                        !row_col_address_i[`SDCB_PRE_ALL_BIT];
  assign bif.pre_all  = start && cmd == SDCB_CMD_PRECHARGE &&
                        row_col_address_i[`SDCB_PRE_ALL_BIT];
  assign bif.bank     = bank_select_i;
  assign bif.row      = row_col_address_i;
  assign burst_last   = burst_q && burst_left == 8'h01;
  assign bif.auto_pre = burst_last && burst_ap && edge_ok;
  assign bif.auto_bank = burst_bank;
  assign bank_open_o  = bif.bank_open;

  // gate history, for power-state entry
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= clk_gate_i;
    end
  end

  // power state follows the gate
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pwr_state_o <= SDCB_PWR_ACTIVE;
    end else if (!clk_gate_i && gate_q) begin
      // refresh code with gate falling enters self refresh
      if (!self_ref && cmd == SDCB_CMD_REFRESH && bif.bank_open == 4'h0) begin
        pwr_state_o <= SDCB_PWR_SELF_REFRESH;
      end else if (burst_q) begin
        pwr_state_o <= SDCB_PWR_SUSPEND;
      end else begin
        pwr_state_o <= SDCB_PWR_POWER_DOWN;
      end
    end else if (clk_gate_i) begin
      pwr_state_o <= SDCB_PWR_ACTIVE;
    end
  end

  // refresh cycle counter, also covers recovery after self refresh
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rf_cnt <= 4'h0;
    end else if (self_ref) begin
      rf_cnt <= 4'(TRC_CYC);
    end else if (edge_ok) begin
      if (start && cmd == SDCB_CMD_REFRESH) begin
        rf_cnt <= 4'(TRC_CYC);
      end else if (rf_cnt != 4'h0) begin
        rf_cnt <= rf_cnt - 4'h1;
      end
    end
  end
  assign refresh_busy_o = (rf_cnt != 4'h0) || self_ref;

  // mode register load, all twelve bits
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mode_o <= `SDCB_MODE_RESET;
    end else if (start && cmd == SDCB_CMD_LOAD_MODE) begin
      mode_o <= row_col_address_i;
    end
  end

  // burst tracker; new read/write restarts, terminate or precharge cuts
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      burst_q    <= 1'b0;
      burst_wr   <= 1'b0;
      burst_ap   <= 1'b0;
      burst_bank <= 2'h0;
      burst_col  <= 8'h00;
      burst_left <= 8'h00;
    end else if (edge_ok) begin
      if (start && (cmd == SDCB_CMD_READ || cmd == SDCB_CMD_WRITE)) begin
        burst_q    <= 1'b1;
        burst_wr   <= (cmd == SDCB_CMD_WRITE);
        burst_ap   <= row_col_address_i[`SDCB_PRE_ALL_BIT];
        burst_bank <= bank_select_i;
        burst_col  <= row_col_address_i[`SDCB_COL_MSB:0];
        burst_left <= 8'(BLEN);
      end else if (start && cmd == SDCB_CMD_BURST_STOP) begin
        burst_q <= 1'b0;
      end else if (burst_q && (bif.pre_all ||
                   (bif.pre_one && bif.bank == burst_bank))) begin
        burst_q <= 1'b0;
      end else if (burst_q) begin
        // inhibit and nop leave the burst running
        burst_col  <= burst_col + 8'h01;
        burst_left <= burst_left - 8'h01;
        if (burst_last) begin
          burst_q <= 1'b0;
        end
      end
    end
  end
  assign burst_active_o = burst_q;

  // write port; the beat is the command cycle or following burst beats
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      array_wr_o      <= 1'b0;
      array_bank_o    <= 2'h0;
      array_row_o     <= 12'h000;
      array_col_o     <= 8'h00;
      array_byte_en_o <= 2'h0;
      array_wdata_o   <= 16'h0000;
    end else begin
      array_wr_o <= 1'b0;
      if (edge_ok && start && cmd == SDCB_CMD_WRITE) begin
        array_wr_o      <= 1'b1;
        array_bank_o    <= bank_select_i;
        array_row_o     <= bif.open_rows[bank_select_i*12 +: 12];
        array_col_o     <= row_col_address_i[`SDCB_COL_MSB:0];
        // mask sampled with its own data; high mask keeps byte
        array_byte_en_o <= ~{high_byte_mask_i, low_byte_mask_i};
        array_wdata_o   <= data_pins_i;
      end else if (edge_ok && burst_q && burst_wr && burst_left > 8'h01 &&
                   cmd != SDCB_CMD_BURST_STOP) begin
        array_wr_o      <= 1'b1;
        array_bank_o    <= burst_bank;
        array_row_o     <= bif.open_rows[burst_bank*12 +: 12];
        array_col_o     <= burst_col + 8'h01;
        array_byte_en_o <= ~{high_byte_mask_i, low_byte_mask_i};
        array_wdata_o   <= data_pins_i;
      end else if (edge_ok && start && cmd == SDCB_CMD_READ) begin
        // read address steers the array so read data follows the burst
        array_bank_o <= bank_select_i;
        array_row_o  <= bif.open_rows[bank_select_i*12 +: 12];
        array_col_o  <= row_col_address_i[`SDCB_COL_MSB:0];
      end else if (edge_ok && burst_q && !burst_wr && burst_left > 8'h01) begin
        array_bank_o <= burst_bank;
        array_row_o  <= bif.open_rows[burst_bank*12 +: 12];
        array_col_o  <= burst_col + 8'h01;
      end
    end
  end

  // read mask pipeline, two valid edges deep
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mask_d1 <= 2'h3;
      rd_d1   <= 1'b0;
    end else if (edge_ok) begin
      // second stage is the output register itself
      mask_d1 <= {high_byte_mask_i, low_byte_mask_i};
      rd_d1   <= burst_q && !burst_wr;
    end
  end

  // output lanes; a high mask two cycles back floats that byte
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      data_pins_o    <= 16'h0000;
      data_pins_oe_o <= 16'h0000;
    end else if (edge_ok) begin
      data_pins_o <= array_rdata_i;
      data_pins_oe_o <= {{8{rd_d1 && !mask_d1[1]}},
                         {8{rd_d1 && !mask_d1[0]}}};
    end
  end

  // read lane enable tracks mask from two edges before
  chk_read_mask_lat: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ($past(edge_ok) && edge_ok && $past(clk_gate_i, 2) && $past(rd_d1)) |->
    data_pins_oe_o[0] == !$past(low_byte_mask_i, 2))
    else $error("read lane enable not from mask two cycles back");

  chk_write_mask: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (start && cmd == SDCB_CMD_WRITE) |=>
    array_wr_o && array_byte_en_o == ~$past({high_byte_mask_i, low_byte_mask_i}))
    else $error("write byte enable does not follow masks");

  chk_mode_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (start && cmd == SDCB_CMD_LOAD_MODE) |=> mode_o == $past(row_col_address_i))
    else $error("mode register not loaded");

  chk_pre_all_banks: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    bif.pre_all |=> bank_open_o == 4'h0)
    else $error("precharge all left a bank open");

  chk_activate_opens: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bif.act && !bif.auto_pre) |=> bank_open_o[$past(bank_select_i)])
    else $error("activate did not open bank");

  sequence s_refresh_start;
    start && cmd == SDCB_CMD_REFRESH;
  endsequence
  chk_refresh_busy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (s_refresh_start ##1 clk_gate_i) |-> refresh_busy_o ##1 refresh_busy_o)
    else $error("refresh busy window too short");

  chk_gate_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !clk_gate_i |=> $stable(mode_o) && $stable(bank_open_o))
    else $error("state moved on a gated edge");

  chk_inhibit_keep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cs_n_i && !burst_q && !bif.auto_pre) |=> $stable(bank_open_o))
    else $error("inhibit changed bank state");

  chk_burst_stop: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (start && cmd == SDCB_CMD_BURST_STOP) |=> !burst_q)
    else $error("burst terminate did not stop burst");

  chk_self_ref_in: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (gate_q && !clk_gate_i && !self_ref && cmd == SDCB_CMD_REFRESH &&
     bank_open_o == 4'h0) |=> self_ref)
    else $error("self refresh not entered");
endmodule : sdcb_core

// ### dv/sdcb_array_model.sv
// array model standing behind the core's array port
`timescale 1ns/1ps
module sdcb_array_model (
  // clock
  input  wire logic        mclk_i,
  // array port
  input  wire logic        wr_i,
  input  wire logic [1:0]  bank_i,
  input  wire logic [7:0]  col_i,
  input  wire logic [1:0]  byte_en_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [0:1023];

  // cleared so a masked lane reads back as zero
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // lane writes; a disabled lane keeps its old byte
  always @(posedge mclk_i) begin
    if (wr_i && byte_en_i[0]) begin
      mem[{bank_i, col_i}][7:0] <= wdata_i[7:0];
    end
    if (wr_i && byte_en_i[1]) begin
      mem[{bank_i, col_i}][15:8] <= wdata_i[15:8];
    end
  end

  // row ignored: one row per bank is enough here
  assign rdata_o = mem[{bank_i, col_i}];
endmodule : sdcb_array_model

// ### dv/sdcb_core_tb.sv
// self-checking bench for the sdram command core
`timescale 1ns/1ps
module sdcb_core_tb;
  import sdcb_pkg::*;
  // strobe codes: cs ras cas we
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, BT = 4'h6;
  localparam logic [3:0] PRE = 4'h2, REF = 4'h1, LMR = 4'h0, NOP = 4'h7;
  localparam logic [3:0] INH = 4'hB;
  localparam int         SR_MIN = 5; // arbitrary stay in self refresh
  logic        mclk_i    = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        gate      = 1'b1;
  logic [3:0]  strobes   = 4'hF;
  logic [1:0]  bank_sel  = 2'h0;
  logic [11:0] addr      = 12'h000;
  logic [1:0]  masks     = 2'h0;
  logic [15:0] wdata     = 16'h0000;
  logic [15:0] dout, oe, awd, ard, seen_d, seen_oe;
  logic [11:0] mode, arow;
  logic [7:0]  acol;
  logic [3:0]  bopen;
  logic [1:0]  abank, ben;
  logic        awr, rbusy, bact;
  sdcb_pwr_t   pwr;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          wr_cnt      = 0;

  always #5 mclk_i = ~mclk_i;

  sdcb_core uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_gate_i(gate),
    .cs_n_i(strobes[3]), .ras_n_i(strobes[2]), .cas_n_i(strobes[1]),
    .we_n_i(strobes[0]), .bank_select_i(bank_sel),
    .row_col_address_i(addr), .low_byte_mask_i(masks[0]),
    .high_byte_mask_i(masks[1]), .data_pins_i(wdata),
    .data_pins_o(dout), .data_pins_oe_o(oe), .array_wr_o(awr),
    .array_bank_o(abank), .array_row_o(arow), .array_col_o(acol),
    .array_byte_en_o(ben), .array_wdata_o(awd), .array_rdata_i(ard),
    .mode_o(mode), .bank_open_o(bopen), .refresh_busy_o(rbusy),
    .pwr_state_o(pwr), .burst_active_o(bact)
  );

  sdcb_array_model partner (
    .mclk_i(mclk_i), .wr_i(awr), .bank_i(abank), .col_i(acol),
    .byte_en_i(ben), .wdata_i(awd), .rdata_o(ard)
  );

  // count write beats, keep the last driven read lanes
  always @(posedge mclk_i) begin
    if (awr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
    if (oe !== 16'h0000) begin
      seen_oe <= oe;
      seen_d  <= dout & oe;
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one command edge then nop; returns just after the taking edge
  task automatic cmd(input logic [3:0] c, input logic [1:0] bs,
                     input logic [11:0] a, input logic g,
                     input logic [1:0] m);
    @(posedge mclk_i);
    strobes  <= c;
    bank_sel <= bs;
    addr     <= a;
    gate     <= g;
    masks    <= m;
    @(posedge mclk_i);
    strobes  <= NOP;
    #1;
  endtask : cmd

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : idle

  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // bounded run; a hang ends as a failure
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wdata     <= 16'h1234;
    #1;
    check("mode", 16'(mode), 16'h0000);
    check("open", 16'(bopen), 16'h0000);
    check("oe", oe, 16'h0000);
    // mode load with all banks idle
    cmd(LMR, 2'h0, 12'hA5C, 1'b1, 2'h0);
    idle(1);
    check("mode", 16'(mode), 16'h0A5C);
    cmd(ACT, 2'h1, 12'h123, 1'b1, 2'h0);
    check("open", 16'(bopen), 16'h0002);
    // write, low byte masked, auto precharge
    wr_cnt = 0;
    cmd(WR, 2'h1, 12'h405, 1'b1, 2'h1);
    check("wr", 16'(awr), 16'h0001);
    check("col", 16'(acol), 16'h0005);
    check("row", 16'(arow), 16'h0123);
    check("ben", 16'(ben), 16'h0002);
    check("wdata", awd, 16'h1234);
    check("bank", 16'(abank), 16'h0001);
    idle(8);
    check("beats", 16'(wr_cnt), 16'h0004);
    check("open", 16'(bopen), 16'h0000);
    // reopen, then read back without auto precharge
    cmd(ACT, 2'h1, 12'h123, 1'b1, 2'h0);
    cmd(RD, 2'h1, 12'h005, 1'b1, 2'h0);
    check("bact", 16'(bact), 16'h0001);
    idle(8);
    check("bact", 16'(bact), 16'h0000);
    check("rdata", seen_d, 16'h1200);
    check("oe", seen_oe, 16'hFFFF);
    check("open", 16'(bopen), 16'h0002);
    cmd(RD, 2'h1, 12'h005, 1'b1, 2'h2);
    idle(8);
    check("oe", seen_oe, 16'h00FF);
    check("rdata", seen_d, 16'h0000);
    // gate dropped inside a read burst suspends it
    cmd(RD, 2'h1, 12'h005, 1'b1, 2'h0);
    cmd(NOP, 2'h0, 12'h000, 1'b0, 2'h0);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_SUSPEND));
    check("bact", 16'(bact), 16'h0001);
    cmd(NOP, 2'h0, 12'h000, 1'b1, 2'h0);
    idle(8);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_ACTIVE));
    check("bact", 16'(bact), 16'h0000);
    // burst cut short right after it starts
    wr_cnt = 0;
    cmd(WR, 2'h1, 12'h000, 1'b1, 2'h0);
    cmd(BT, 2'h0, 12'h000, 1'b1, 2'h0);
    idle(6);
    check("short", 16'(wr_cnt), 16'h0002);
    // single and all-bank precharge
    cmd(ACT, 2'h2, 12'h0FF, 1'b1, 2'h0);
    cmd(PRE, 2'h1, 12'h000, 1'b1, 2'h0);
    idle(2);
    check("open", 16'(bopen), 16'h0004);
    cmd(ACT, 2'h0, 12'h010, 1'b1, 2'h0);
    cmd(PRE, 2'h1, 12'h400, 1'b1, 2'h0);
    idle(2);
    check("open", 16'(bopen), 16'h0000);
    // deselected and gated edges open no bank; the gated one enters power down
    cmd(INH, 2'h3, 12'h010, 1'b1, 2'h0);
    check("open", 16'(bopen), 16'h0000);
    cmd(ACT, 2'h3, 12'h010, 1'b0, 2'h0);
    check("open", 16'(bopen), 16'h0000);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_POWER_DOWN));
    cmd(NOP, 2'h0, 12'h000, 1'b1, 2'h0);
    idle(1);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_ACTIVE));
    // auto refresh refuses commands while busy
    cmd(REF, 2'h0, 12'hFFF, 1'b1, 2'h0);
    check("busy", 16'(rbusy), 16'h0001);
    cmd(ACT, 2'h0, 12'h010, 1'b1, 2'h0);
    check("open", 16'(bopen), 16'h0000);
    idle(7);
    cmd(ACT, 2'h0, 12'h010, 1'b1, 2'h0);
    check("open", 16'(bopen), 16'h0001);
    cmd(PRE, 2'h0, 12'h400, 1'b1, 2'h0);
    idle(2);
    // self refresh entry, stay, exit
    cmd(REF, 2'h0, 12'h000, 1'b0, 2'h0);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_SELF_REFRESH));
    idle(SR_MIN);
    cmd(NOP, 2'h0, 12'h000, 1'b1, 2'h0);
    cmd(NOP, 2'h0, 12'h000, 1'b1, 2'h0);
    idle(7);
    check("pwr", 16'(pwr), 16'(SDCB_PWR_ACTIVE));
    cmd(REF, 2'h0, 12'h000, 1'b1, 2'h0);
    idle(7);
    cmd(ACT, 2'h2, 12'h0AA, 1'b1, 2'h0);
    check("open", 16'(bopen), 16'h0004);
    report_and_stop();
  end
endmodule : sdcb_core_tb
